// File: core/emu_serial_read_protect_pkg.sv
/*
 * Constants for the configuration register bank: register offsets,
 * reset values, write masks, field positions and counts.
 * Assumes a 32-bit APB slave with byte addresses below 8'h40.
 */
package emu_serial_read_protect_pkg;

	// ******************************************************
	// Bus shape
	// ******************************************************
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned STRB_W = 4;
	localparam int unsigned NUM_REGS = 14;
	localparam logic [3:0] LAST_INDEX = 4'hd;

	// ******************************************************
	// Register byte offsets
	// ******************************************************
	localparam logic [7:0] OFS_SYSTEM_CONFIG_0 = 8'h00;
	localparam logic [7:0] OFS_EXT_IRQ_ENABLE_0 = 8'h04;
	localparam logic [7:0] OFS_PERIPH_CLOCK_GATE_0 = 8'h08;
	localparam logic [7:0] OFS_PERIPH_CLOCK_GATE_1 = 8'h0c;
	localparam logic [7:0] OFS_EMU_CLOCK_GATE_0 = 8'h10;
	localparam logic [7:0] OFS_EMU_CLOCK_GATE_1 = 8'h14;
	localparam logic [7:0] OFS_CLOCK_GATE_QUALIFIER_0 = 8'h18;
	localparam logic [7:0] OFS_CLOCK_GATE_QUALIFIER_1 = 8'h1c;
	localparam logic [7:0] OFS_TIMER_EXT_CLOCK_SELECT = 8'h20;
	localparam logic [7:0] OFS_EXT_IRQ_ENABLE_1 = 8'h24;
	localparam logic [7:0] OFS_EXT_IRQ_ENABLE_2 = 8'h28;
	localparam logic [7:0] OFS_EMU_SERIAL_PROTECTION = 8'h2c;
	localparam logic [7:0] OFS_SYSTEM_CONFIG_1 = 8'h30;
	localparam logic [7:0] OFS_PART_IDENTIFIER = 8'h34;

	// Word indices used by the core logic
	localparam logic [3:0] IDX_PCG0 = OFS_PERIPH_CLOCK_GATE_0[5:2];
	localparam logic [3:0] IDX_PCG1 = OFS_PERIPH_CLOCK_GATE_1[5:2];
	localparam logic [3:0] IDX_ECG0 = OFS_EMU_CLOCK_GATE_0[5:2];
	localparam logic [3:0] IDX_ECG1 = OFS_EMU_CLOCK_GATE_1[5:2];
	localparam logic [3:0] IDX_QUAL0 = OFS_CLOCK_GATE_QUALIFIER_0[5:2];
	localparam logic [3:0] IDX_QUAL1 = OFS_CLOCK_GATE_QUALIFIER_1[5:2];
	localparam logic [3:0] IDX_TIMSEL = OFS_TIMER_EXT_CLOCK_SELECT[5:2];
	localparam logic [3:0] IDX_PROT = OFS_EMU_SERIAL_PROTECTION[5:2];
	localparam logic [3:0] IDX_PART_ID = OFS_PART_IDENTIFIER[5:2];

	// ******************************************************
	// Reset values and writable bits, in index order
	// ******************************************************
	localparam logic [31:0] RST_PROT = 32'h0000_0000;
	localparam logic [31:0] MASK_PROT = 32'h0000_0073;
	localparam logic [31:0] RST_TABLE [NUM_REGS] = '{
		32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 32'hffff_ffff,
		32'hffff_ffff, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, RST_PROT,
		32'h0000_0000, 32'h0000_0000
	};
	localparam logic [31:0] MASK_TABLE [NUM_REGS] = '{
		32'h0000_0fff, 32'h0000_ffff, 32'hffff_ffff, 32'hffff_ffff,
		32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
		32'h0000_03ff, 32'h0000_ffff, 32'h0000_ffff, MASK_PROT,
		32'h0000_00ff, 32'h0000_0000
	};
	// Arbitrary neutral identifier value
	localparam logic [31:0] PART_ID_VALUE = 32'h0000_0001;

	// ******************************************************
	// Protection fields
	// ******************************************************
	localparam int unsigned SPI_UNITS = 3;
	localparam int unsigned SPI_PROT_LSB = 4;
	localparam int unsigned UART_UNITS = 2;
	localparam int unsigned UART_PROT_LSB = 0;
	localparam int unsigned TIMSEL_W = 10;

	// ******************************************************
	// Flash power-on delay, in oscillator ticks
	// ******************************************************
	localparam int unsigned PON_CNT_W = 8;
	localparam logic [PON_CNT_W-1:0] FLASH_PON_RC_TICKS = 8'h10;

	typedef enum logic [1:0] {PON_READY, PON_WAIT} pon_state_t;

endpackage : emu_serial_read_protect_pkg

// File: core/serial_read_guard.sv
/*
 * One receive-FIFO read qualifier for a serial unit.
 * Assumes the read strobe and emulation flag are on CLOCK.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_read_guard (
	input wire logic clock,
	input wire logic rst,
	input wire logic emu_mode,
	input wire logic protect,
	input wire logic rx_read,
	output logic rx_pop
);

	// ******************************************************
	// Pop qualifier
	// ******************************************************
	// A protected read still returns the head frame; only the pop and
	// the flag update that rides on it are withheld.
	always_ff @(posedge clock) begin
		if (rst) begin
			rx_pop <= 1'b0;
		end else begin
			rx_pop <= rx_read & ~(emu_mode & protect); // RL1 RL7 RL12
		end
	end

	a_protected_no_pop: assert property (@(posedge clock) disable iff (rst)
		rx_read && emu_mode && protect |=> !rx_pop) // RL12
		else $error("protected emulation read popped the fifo");

	a_plain_read_pops: assert property (@(posedge clock) disable iff (rst)
		rx_read && !(emu_mode && protect) |=> rx_pop) // RL7
		else $error("unprotected read did not pop");

	a_no_spurious_pop: assert property (@(posedge clock) disable iff (rst)
		!$past(rx_read) |-> !rx_pop) // RL1
		else $error("pop without a read");

endmodule : serial_read_guard

`default_nettype wire

// File: core/emu_serial_read_protect.sv
/*
 * Configuration register bank with serial-read protection in
 * emulation, clock gate enables, timer clock select, reference and
 * oscillator tick distribution, flash power-on delay.
 * Assumes an APB master on CLOCK; oscillator ticks arrive unsynced.
 */
// Register access over APB was chosen for this implementation.
// Operation
// RL1 - Unprotected read in emulation pops the frame and may change flags
// RL2 - Protection register sits at 2Ch, cleared to zero on reset
// RL3 - Software writes zero into the reserved bits 31:7
// RL4 - Bits 6:4 protect three buffered SPI units from emulation pops
// RL5 - Bits 1:0 protect two UARTs from emulation pops
// RL6 - Reserved bits 3:2 of protection register always read zero
// RL7 - Cleared protection bit means emulation reads pop as normal
// RL8 - Registers decoded at word offsets 00h through 34h
// RL9 - Module clocks come from system clock, gated by paired registers
// RL10 - Oscillator ticks drive wake-up timer and flash power-on delay
// RL11 - Counters may take the reference tick, free of system clock
// RL12 - Protected read leaves pointer, level and flags untouched
`timescale 1ns/1ps
`default_nettype none

module emu_serial_read_protect (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [emu_serial_read_protect_pkg::ADDR_W-1:0] PADDR,
	input wire logic [emu_serial_read_protect_pkg::DATA_W-1:0] PWDATA,
	input wire logic [emu_serial_read_protect_pkg::STRB_W-1:0] PSTRB,
	output logic [emu_serial_read_protect_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EMU_MODE,
	input wire logic [emu_serial_read_protect_pkg::SPI_UNITS-1:0] SPI_RX_READ,
	input wire logic [emu_serial_read_protect_pkg::UART_UNITS-1:0] UART_RX_READ,
	output logic [emu_serial_read_protect_pkg::SPI_UNITS-1:0] SPI_RX_POP,
	output logic [emu_serial_read_protect_pkg::UART_UNITS-1:0] UART_RX_POP,
	output logic [31:0] MODULE_CLK_EN_0,
	output logic [31:0] MODULE_CLK_EN_1,
	output logic [emu_serial_read_protect_pkg::TIMSEL_W-1:0] TIM_EXTCLK_SEL,
	input wire logic REF_TICK,
	output logic TIMER_REF_TICK,
	input wire logic RC_TICK,
	output logic WAKEUP_TICK,
	input wire logic LOWPOWER_EXIT,
	output logic FLASH_READY
);
	import emu_serial_read_protect_pkg::*;

	// ******************************************************
	// Decode helpers
	// ******************************************************
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a[1:0] == 2'b00) && (a[7:6] == 2'b00) &&
			(a[5:2] <= LAST_INDEX);
	endfunction : reg_hit

	function automatic logic [3:0] reg_index(input logic [7:0] a);
		reg_index = a[5:2];
	endfunction : reg_index

	function automatic logic [31:0] strobe_mask(input logic [3:0] s);
		strobe_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : strobe_mask

	// Clock runs only when gate bit set and qualifier does not kill it;
	// in emulation the emulation gate must also allow it.
	function automatic logic [31:0] gate_enable(input logic [31:0] pcg,
		input logic [31:0] qual, input logic [31:0] ecg, input logic emu);
		gate_enable = pcg & ~qual & (emu ? ecg : 32'hffff_ffff);
	endfunction : gate_enable

	// ******************************************************
	// APB slave
	// ******************************************************
	logic [31:0] regs_r [NUM_REGS];
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic setup_phase;
	logic wr_en;
	logic [3:0] wr_idx;
	logic [31:0] rd_val;

	assign setup_phase = PSEL & ~PENABLE;
	assign wr_idx = reg_index(PADDR);
	assign wr_en = PSEL & PENABLE & pready_r & PWRITE & reg_hit(PADDR); // RL8

	// One wait-free access phase: ready rises the cycle after setup.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= setup_phase;
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		if (reg_hit(PADDR)) begin
			if (reg_index(PADDR) == IDX_PART_ID) begin
				rd_val = PART_ID_VALUE;
			end else begin
				rd_val = regs_r[reg_index(PADDR)]; // RL8
			end
		end
	end

	// Read data and error latched at setup, stable through access.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup_phase) begin
			prdata_r <= PWRITE ? 32'h0000_0000 : rd_val;
			pslverr_r <= ~reg_hit(PADDR); // RL8
		end else if (!PSEL) begin
			pslverr_r <= 1'b0;
		end
	end

	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;

	// ******************************************************
	// Register storage
	// ******************************************************
	// Masked storage keeps reserved bits at their reset level, so a
	// careless write to them is harmless.
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
		if (i == IDX_PART_ID) begin : g_const
			always_ff @(posedge CLOCK) begin
				regs_r[i] <= PART_ID_VALUE;
			end
		end else begin : g_rw
			always_ff @(posedge CLOCK) begin
				if (SYS_RST) begin
					regs_r[i] <= RST_TABLE[i]; // RL2
				end else if (wr_en && wr_idx == 4'(i)) begin
					regs_r[i] <= (regs_r[i] & ~(strobe_mask(PSTRB) &
						MASK_TABLE[i])) | (PWDATA & strobe_mask(PSTRB) &
						MASK_TABLE[i]); // RL3 RL6
				end
			end
		end
	end

	// ******************************************************
	// Serial read guards
	// ******************************************************
	for (genvar s = 0; s < SPI_UNITS; s++) begin : g_spi
		serial_read_guard u_guard (
			.clock(CLOCK),
			.rst(SYS_RST),
			.emu_mode(EMU_MODE),
			.protect(regs_r[IDX_PROT][SPI_PROT_LSB+s]), // RL4
			.rx_read(SPI_RX_READ[s]),
			.rx_pop(SPI_RX_POP[s])
		);
	end

	for (genvar u = 0; u < UART_UNITS; u++) begin : g_uart
		serial_read_guard u_guard (
			.clock(CLOCK),
			.rst(SYS_RST),
			.emu_mode(EMU_MODE),
			.protect(regs_r[IDX_PROT][UART_PROT_LSB+u]), // RL5
			.rx_read(UART_RX_READ[u]),
			.rx_pop(UART_RX_POP[u])
		);
	end

	// ******************************************************
	// Module clock enables and timer clock select
	// ******************************************************
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			MODULE_CLK_EN_0 <= 32'h0000_0000;
			MODULE_CLK_EN_1 <= 32'h0000_0000;
		end else begin
			MODULE_CLK_EN_0 <= gate_enable(regs_r[IDX_PCG0],
				regs_r[IDX_QUAL0], regs_r[IDX_ECG0], EMU_MODE); // RL9
			MODULE_CLK_EN_1 <= gate_enable(regs_r[IDX_PCG1],
				regs_r[IDX_QUAL1], regs_r[IDX_ECG1], EMU_MODE); // RL9
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			TIM_EXTCLK_SEL <= '0;
		end else begin
			TIM_EXTCLK_SEL <= regs_r[IDX_TIMSEL][TIMSEL_W-1:0]; // RL11
		end
	end

	// ******************************************************
	// Tick synchronisers
	// ******************************************************
	logic ref_meta_r;
	logic ref_sync_r;
	logic ref_prev_r;
	logic rc_meta_r;
	logic rc_sync_r;
	logic rc_prev_r;
	logic rc_edge;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			ref_meta_r <= 1'b0;
			ref_sync_r <= 1'b0;
			ref_prev_r <= 1'b0;
			TIMER_REF_TICK <= 1'b0;
		end else begin
			ref_meta_r <= REF_TICK;
			ref_sync_r <= ref_meta_r;
			ref_prev_r <= ref_sync_r;
			// Not divided or gated: timebase survives slow clock settings
			TIMER_REF_TICK <= ref_sync_r & ~ref_prev_r; // RL11
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			rc_meta_r <= 1'b0;
			rc_sync_r <= 1'b0;
			rc_prev_r <= 1'b0;
			WAKEUP_TICK <= 1'b0;
		end else begin
			rc_meta_r <= RC_TICK;
			rc_sync_r <= rc_meta_r;
			rc_prev_r <= rc_sync_r;
			WAKEUP_TICK <= rc_edge; // RL10
		end
	end

	assign rc_edge = rc_sync_r & ~rc_prev_r;

	// ******************************************************
	// Flash power-on delay
	// ******************************************************
	pon_state_t pon_state_r;
	logic [PON_CNT_W-1:0] pon_cnt_r;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			pon_state_r <= PON_READY;
			pon_cnt_r <= '0;
		end else begin
			unique case (pon_state_r)
				PON_READY: begin
					if (LOWPOWER_EXIT) begin
						pon_state_r <= PON_WAIT;
						pon_cnt_r <= '0;
					end
				end
				PON_WAIT: begin
					if (rc_edge) begin
						if (pon_cnt_r == FLASH_PON_RC_TICKS - 8'h01) begin
							pon_state_r <= PON_READY; // RL10
						end
						pon_cnt_r <= pon_cnt_r + 8'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			FLASH_READY <= 1'b1;
		end else begin
			FLASH_READY <= (pon_state_r == PON_READY) & ~LOWPOWER_EXIT;
		end
	end

	// ******************************************************
	// Checks
	// ******************************************************
	a_prot_reset_zero: assert property (@(posedge CLOCK)
		$fell(SYS_RST) |-> regs_r[IDX_PROT] == 32'h0000_0000) // RL2
		else $error("protection register not zero after reset");

	a_prot_reserved_zero: assert property (@(posedge CLOCK)
		disable iff (SYS_RST)
		regs_r[IDX_PROT][3:2] == 2'b00 && regs_r[IDX_PROT][31:7] == '0) // RL6
		else $error("reserved protection bits not zero");

	a_prot_write_lands: assert property (@(posedge CLOCK)
		disable iff (SYS_RST)
		wr_en && wr_idx == IDX_PROT && PSTRB == 4'hf |=>
		regs_r[IDX_PROT] == ($past(PWDATA) & MASK_PROT)) // RL2
		else $error("protection register write lost");

	a_apb_ready_next: assert property (@(posedge CLOCK)
		disable iff (SYS_RST)
		PSEL && !PENABLE |=> PREADY ##1 !PREADY) // RL8
		else $error("ready not one cycle after setup");

	a_unmapped_error: assert property (@(posedge CLOCK)
		disable iff (SYS_RST)
		PSEL && !PENABLE && !reg_hit(PADDR) |=>
		PSLVERR && PRDATA == 32'h0000_0000) // RL8
		else $error("unmapped access not flagged");

	a_qualifier_kills: assert property (@(posedge CLOCK)
		disable iff (SYS_RST)
		regs_r[IDX_QUAL0][0] && regs_r[IDX_PCG0][0] |=>
		!MODULE_CLK_EN_0[0]) // RL9
		else $error("qualified gate left clock running");

	a_emu_stretch: assert property (@(posedge CLOCK)
		disable iff (SYS_RST)
		EMU_MODE && !regs_r[IDX_ECG1][0] |=> !MODULE_CLK_EN_1[0]) // RL9
		else $error("emulation gate left clock running");

	a_timer_select: assert property (@(posedge CLOCK)
		disable iff (SYS_RST)
		##1 TIM_EXTCLK_SEL == $past(regs_r[IDX_TIMSEL][9:0])) // RL11
		else $error("timer clock select not following register");

	a_wakeup_pulse: assert property (@(posedge CLOCK)
		disable iff (SYS_RST)
		WAKEUP_TICK |=> !WAKEUP_TICK) // RL10
		else $error("wake-up tick longer than one cycle");

	a_flash_delay: assert property (@(posedge CLOCK)
		disable iff (SYS_RST)
		LOWPOWER_EXIT && pon_state_r == PON_READY |=>
		!FLASH_READY ##1 !FLASH_READY) // RL10
		else $error("flash ready before power-on delay");

endmodule : emu_serial_read_protect

`default_nettype wire

// File: tb/debug_core_model.sv
/*
 * Debug core side: emulation flag and receive FIFO read strobes.
 * Assumes requests from the bench arrive on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module debug_core_model
	import emu_serial_read_protect_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic emu_req,
	input wire logic go,
	input wire logic [SPI_UNITS+UART_UNITS-1:0] rd_req,
	output logic emu_mode,
	output logic [SPI_UNITS-1:0] spi_rd,
	output logic [UART_UNITS-1:0] uart_rd
);
	// Flag and strobes move together so a read sees the mode it was meant for
	always_ff @(posedge clock) begin
		if (rst) begin
			emu_mode <= 1'b0;
			{spi_rd, uart_rd} <= '0;
		end else begin
			emu_mode <= emu_req;
			{spi_rd, uart_rd} <= go ? rd_req : '0;
		end
	end
endmodule : debug_core_model
`default_nettype wire

// File: tb/emu_serial_read_protect_bench.sv
/*
 * Self-checking bench for the configuration bank and read protection.
 * Assumes the design package and the debug core model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module emu_serial_read_protect_bench;
	import emu_serial_read_protect_pkg::*;
	logic CLOCK = 0;
	logic SYS_RST = 1;
	logic PSEL = 0;
	logic PENABLE = 0;
	logic PWRITE = 0;
	logic [ADDR_W-1:0] PADDR = '0;
	logic [DATA_W-1:0] PWDATA = '0;
	logic [DATA_W-1:0] PRDATA;
	logic [STRB_W-1:0] PSTRB = 4'hf;
	logic PREADY, PSLVERR, EMU_MODE, TIMER_REF_TICK, WAKEUP_TICK, FLASH_READY;
	logic REF_TICK = 0;
	logic RC_TICK = 0;
	logic LOWPOWER_EXIT = 0;
	logic emu_req = 0;
	logic go = 0;
	logic ticking = 0;
	logic rd_d = 0;
	logic [4:0] rd_req = '0;
	logic [SPI_UNITS-1:0] SPI_RX_READ, SPI_RX_POP;
	logic [UART_UNITS-1:0] UART_RX_READ, UART_RX_POP;
	logic [31:0] MODULE_CLK_EN_0, MODULE_CLK_EN_1, v, w, u;
	logic [31:0] seed = 32'h2402;
	logic [TIMSEL_W-1:0] TIM_EXTCLK_SEL;
	logic [32:0] exp_q[$];
	logic [4:0] pop_q[$];
	int n_fail = 0;
	int num_checks = 0;
	int ref_rise = 0;
	int ref_seen = 0;
	int rc_rise = 0;
	int rc_seen = 0;
	int c = 0;
	int n;

	emu_serial_read_protect dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .EMU_MODE(EMU_MODE), .SPI_RX_READ(SPI_RX_READ),
		.UART_RX_READ(UART_RX_READ), .SPI_RX_POP(SPI_RX_POP),
		.UART_RX_POP(UART_RX_POP), .MODULE_CLK_EN_0(MODULE_CLK_EN_0),
		.MODULE_CLK_EN_1(MODULE_CLK_EN_1), .TIM_EXTCLK_SEL(TIM_EXTCLK_SEL),
		.REF_TICK(REF_TICK), .TIMER_REF_TICK(TIMER_REF_TICK),
		.RC_TICK(RC_TICK), .WAKEUP_TICK(WAKEUP_TICK),
		.LOWPOWER_EXIT(LOWPOWER_EXIT), .FLASH_READY(FLASH_READY));

	debug_core_model partner (.clock(CLOCK), .rst(SYS_RST),
		.emu_req(emu_req), .go(go), .rd_req(rd_req), .emu_mode(EMU_MODE),
		.spi_rd(SPI_RX_READ), .uart_rd(UART_RX_READ));

	// ******************************************************
	// Helpers
	// ******************************************************
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	// Leaves the bus in access phase so the next setup can follow at once
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d, input logic [32:0] e);
		int k;
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		if (!wr) begin
			exp_q.push_back(e);
		end
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		k = 0;
		do begin
			@(posedge CLOCK);
			k++;
		end while (PREADY !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_fail++;
			conclude();
		end
	endtask : apb

	task automatic idle();
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLOCK);
	endtask : idle

	// ******************************************************
	// Clock, ticks, monitor, watchdog
	// ******************************************************
	initial begin
		forever #5 CLOCK = ~CLOCK;
	end

	always @(posedge CLOCK) begin
		if (ticking) begin
			c++;
			// Counts move by NBA so a reader on the same edge sees a settled value
			if (c % 7 == 0) begin
				REF_TICK <= !REF_TICK;
				if (!REF_TICK) ref_rise <= ref_rise + 1;
			end
			if (c % 3 == 0) begin
				RC_TICK <= !RC_TICK;
				if (!RC_TICK) rc_rise <= rc_rise + 1;
			end
		end
	end

	always @(posedge CLOCK) begin
		if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1 &&
				PWRITE === 1'b0 && exp_q.size() > 0)
			check({PSLVERR, PRDATA}, exp_q.pop_front());
		if (rd_d && pop_q.size() > 0)
			check({28'h0, SPI_RX_POP, UART_RX_POP}, {28'h0, pop_q.pop_front()});
		rd_d = |{SPI_RX_READ, UART_RX_READ};
		if (TIMER_REF_TICK === 1'b1) ref_seen++;
		if (WAKEUP_TICK === 1'b1) rc_seen++;
	end

	initial begin
		#200000;
		n_fail++;
		conclude();
	end

	// ******************************************************
	// Scenarios
	// ******************************************************
	initial begin
		repeat (10) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		@(posedge CLOCK);
		for (int i = 0; i < NUM_REGS; i++)
			apb(0, 8'(4 * i), 0, {1'b0, i == 13 ? PART_ID_VALUE : RST_TABLE[i]});
		apb(0, 8'h38, 0, {1'b1, 32'h0});
		apb(0, 8'h2e, 0, {1'b1, 32'h0});
		for (int i = 0; i < NUM_REGS; i++) begin
			v = rnd();
			if (i == 11) v = v & 32'h0000_007f;
			if (i == 8) u = v;
			apb(1, 8'(4 * i), v, 0);
			apb(0, 8'(4 * i), 0, {1'b0, i == 13 ? PART_ID_VALUE : v & MASK_TABLE[i]});
		end
		// Byte strobes: only byte 0 of the second write may land
		apb(1, OFS_EXT_IRQ_ENABLE_0, 32'h0000_a5a5, 0);
		PSTRB <= 4'h1;
		apb(1, OFS_EXT_IRQ_ENABLE_0, 32'hffff_ff3c, 0);
		PSTRB <= 4'hf;
		apb(0, OFS_EXT_IRQ_ENABLE_0, 0, {1'b0, 32'h0000_a53c});
		idle();
		repeat (2) @(posedge CLOCK);
		check({23'h0, TIM_EXTCLK_SEL}, {23'h0, u[9:0]});
		v = rnd();
		apb(1, OFS_TIMER_EXT_CLOCK_SELECT, v, 0);
		idle();
		repeat (2) @(posedge CLOCK);
		check({23'h0, TIM_EXTCLK_SEL}, {23'h0, v[9:0]});
		for (int k = 0; k < 2; k++) begin
			v = rnd();
			w = rnd();
			u = rnd();
			apb(1, 8'(OFS_PERIPH_CLOCK_GATE_0 + 4 * k), v, 0);
			apb(1, 8'(OFS_CLOCK_GATE_QUALIFIER_0 + 4 * k), w, 0);
			apb(1, 8'(OFS_EMU_CLOCK_GATE_0 + 4 * k), u, 0);
			idle();
			repeat (2) @(posedge CLOCK);
			check({1'b0, k ? MODULE_CLK_EN_1 : MODULE_CLK_EN_0}, {1'b0, v & ~w});
			emu_req <= 1'b1;
			repeat (3) @(posedge CLOCK);
			check({1'b0, k ? MODULE_CLK_EN_1 : MODULE_CLK_EN_0}, {1'b0, v & ~w & u});
			emu_req <= 1'b0;
		end
		for (int t = 0; t < 8; t++) begin
			v = rnd() & MASK_PROT;
			apb(1, OFS_EMU_SERIAL_PROTECTION, v, 0);
			idle();
			emu_req <= t[0];
			go <= 1'b1;
			for (int j = 0; j < 3; j++) begin
				w = rnd();
				rd_req <= w[4:0];
				if (w[4:0] != 5'h00)
					pop_q.push_back(t[0] ? w[4:0] & ~{v[6:4], v[1:0]} : w[4:0]);
				@(posedge CLOCK);
			end
			go <= 1'b0;
			repeat (3) @(posedge CLOCK);
		end
		ticking <= 1'b1;
		repeat (19) @(posedge CLOCK);
		// Sync delay: a rise launched one edge before the exit pulse counts
		n = rc_rise;
		@(posedge CLOCK);
		LOWPOWER_EXIT <= 1'b1;
		@(posedge CLOCK);
		LOWPOWER_EXIT <= 1'b0;
		@(posedge CLOCK);
		check({32'h0, FLASH_READY}, 33'h0);
		for (int z = 0; z < 300 && FLASH_READY !== 1'b1; z++) @(posedge CLOCK);
		n = rc_rise - n;
		check({32'h0, FLASH_READY}, 33'h1);
		check(33'(n), 33'(FLASH_PON_RC_TICKS));
		ticking <= 1'b0;
		repeat (10) @(posedge CLOCK);
		check(33'(ref_seen), 33'(ref_rise));
		check(33'(rc_seen), 33'(rc_rise));
		conclude();
	end
endmodule : emu_serial_read_protect_bench
`default_nettype wire
